// File: rtl/exec_unit.sv
// execution unit for literal return, rotates, literal subtract, sleep
// assumes the fetch side presents the addressed file value with each
// issue and that the return stack supplies its top entry continuously
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps

// How it works
// - literal return loads accumulator, program counter from stack
// - literal return is one word, two cycles
// - return pops the hardware return stack
// - rotate left: carry into bit0, bit7 out
// - rotate destination: 0 accumulator, 1 file register
// - rotate right: carry into bit7, bit0 out
// - right rotate to file keeps accumulator unchanged
// - literal minus accumulator stored in accumulator
// - carry, nibble carry compare; zero on zero result
// - sleep clears watchdog counter and prescaler
// - sleep clears powerdown flag, sets timeout flag
// - sleep then halts with oscillator stopped
module exec_unit
(
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // instruction issue
   input  wire logic                issue_valid,
   input  wire exec_pkg::op_t       issue_op,
   input  wire logic [7:0]          issue_operand,
   input  wire logic                issue_dest,
   input  wire logic [7:0]          file_rdata,
   output logic                     issue_ready,
   // return stack
   input  wire logic [14:0]         stack_top,
   output logic                     stack_pop,
   // file register write-back
   output logic                     file_wr_en,
   output logic [7:0]               file_wdata,
   // core state
   output logic [7:0]               accumulator,
   output logic [14:0]              program_counter,
   output logic                     carry,
   output logic                     nibble_carry,
   output logic                     zero,
   output logic                     timeout_flag_n,
   output logic                     powerdown_flag_n,
   output logic                     osc_stopped,
   // wake from low power
   input  wire logic                wake,
   // software register port
   input  wire logic [3:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [31:0]              reg_rdata
);

   // every flip-flop of the unit
   typedef struct packed {
      exec_pkg::state_t state;
      logic [7:0]       acc;
      logic [14:0]      pc;
      logic             carry;
      logic             nibble;
      logic             zero;
      logic             to_n;
      logic             pd_n;
      logic [7:0]       wdog;
      logic [7:0]       presc;
      logic             pop;
      logic             fwr;
      logic [7:0]       fdata;
      logic [31:0]      rdata;
   } state_bits_t;

   state_bits_t cur;
   state_bits_t next_cur;

   alu_if alu_bus ();

   logic take;
   logic is_ret;
   logic is_rot;
   logic is_sub;
   logic is_sleep;
   logic [31:0] read_mux;

   rot_sub_alu alu_inst
   (
      .port (alu_bus.alu)
   );

   // feed the arithmetic unit from the issue port and live state
   assign alu_bus.op        = issue_op;
   assign alu_bus.operand   = issue_operand;
   assign alu_bus.file_data = file_rdata;
   assign alu_bus.acc       = cur.acc;
   assign alu_bus.carry_in  = cur.carry;

   // accept only in the run state; the flush cycle stalls the issue
   assign issue_ready = (cur.state == exec_pkg::ST_RUN);
   assign take        = issue_valid && issue_ready;
   assign is_ret      = take && (issue_op == exec_pkg::OP_RET_LIT);
   assign is_rot      = take && ((issue_op == exec_pkg::OP_ROT_L)
                                 || (issue_op == exec_pkg::OP_ROT_R));
   assign is_sub      = take && (issue_op == exec_pkg::OP_SUB_LIT);
   assign is_sleep    = take && (issue_op == exec_pkg::OP_SLEEP);

   // read data selection, unmapped offsets read zero
   always_comb
   begin
      read_mux = 32'h0000_0000;
      unique case (reg_addr)
         exec_pkg::OFS_ACC:
            read_mux = {24'h00_0000, cur.acc};
         exec_pkg::OFS_FLAGS:
         begin
            read_mux[exec_pkg::FLAG_CARRY]  = cur.carry;
            read_mux[exec_pkg::FLAG_NIBBLE] = cur.nibble;
            read_mux[exec_pkg::FLAG_ZERO]   = cur.zero;
            read_mux[exec_pkg::FLAG_TO_N]   = cur.to_n;
            read_mux[exec_pkg::FLAG_PD_N]   = cur.pd_n;
         end
         exec_pkg::OFS_PC:
            read_mux = {17'h0_0000, cur.pc};
         exec_pkg::OFS_WDOG:
            read_mux = {16'h0000, cur.presc, cur.wdog};
         default:
            read_mux = 32'h0000_0000;
      endcase
   end

   // next-state logic for the whole unit
   always_comb
   begin
      next_cur       = cur;
      next_cur.pop   = 1'b0;
      next_cur.fwr   = 1'b0;
      next_cur.rdata = 32'h0000_0000;

      // read data stand only in the cycle after the strobe
      if (reg_rd)
      begin
         next_cur.rdata = read_mux;
      end

      // software writes first, so an instruction in the same cycle wins
      if (reg_wr && (reg_addr == exec_pkg::OFS_ACC))
      begin
         next_cur.acc = reg_wdata[7:0];
      end
      if (reg_wr && (reg_addr == exec_pkg::OFS_FLAGS))
      begin
         next_cur.carry  = reg_wdata[exec_pkg::FLAG_CARRY];
         next_cur.nibble = reg_wdata[exec_pkg::FLAG_NIBBLE];
         next_cur.zero   = reg_wdata[exec_pkg::FLAG_ZERO];
      end

      // free-running watchdog while the oscillator runs
      if (cur.state != exec_pkg::ST_SLEEP)
      begin
         next_cur.presc = cur.presc + 8'h01;
         if (cur.presc == 8'hff)
         begin
            next_cur.wdog = cur.wdog + 8'h01;
         end
      end

      unique case (cur.state)
         exec_pkg::ST_RUN:
         begin
            // every instruction but the return advances the counter by one
            if (take && !is_ret)
            begin
               next_cur.pc = cur.pc + 15'h0001;
            end
            if (is_ret)
            begin
               next_cur.acc   = issue_operand;
               next_cur.pc    = stack_top;
               next_cur.pop   = 1'b1;
               next_cur.state = exec_pkg::ST_FLUSH;
            end
            if (is_rot)
            begin
               next_cur.carry = alu_bus.carry_out;
               if (issue_dest)
               begin
                  next_cur.fwr   = 1'b1;
                  next_cur.fdata = alu_bus.result;
               end
               else
               begin
                  next_cur.acc = alu_bus.result;
               end
            end
            if (is_sub)
            begin
               next_cur.acc    = alu_bus.result;
               next_cur.carry  = alu_bus.carry_out;
               next_cur.nibble = alu_bus.nibble_out;
               next_cur.zero   = alu_bus.zero_out;
            end
            if (is_sleep)
            begin
               next_cur.wdog  = exec_pkg::WDOG_CLEAR;
               next_cur.presc = exec_pkg::RST_PRESC;
               next_cur.to_n  = 1'b1;
               next_cur.pd_n  = 1'b0;
               next_cur.state = exec_pkg::ST_SLEEP;
            end
         end
         exec_pkg::ST_FLUSH:
         begin
            // second cycle of the return: nothing is issued
            next_cur.state = exec_pkg::ST_RUN;
         end
         exec_pkg::ST_SLEEP:
         begin
            // halted until woken; counter and flags hold
            if (wake)
            begin
               next_cur.state = exec_pkg::ST_RUN;
            end
         end
         default:
            next_cur.state = exec_pkg::ST_RUN;
      endcase
   end

   // register the whole state
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cur.state  <= exec_pkg::ST_RUN;
         cur.acc    <= exec_pkg::RST_ACC;
         cur.pc     <= exec_pkg::RST_PC;
         cur.carry  <= 1'b0;
         cur.nibble <= 1'b0;
         cur.zero   <= 1'b0;
         cur.to_n   <= exec_pkg::RST_TO_N;
         cur.pd_n   <= exec_pkg::RST_PD_N;
         cur.wdog   <= exec_pkg::RST_WDOG;
         cur.presc  <= exec_pkg::RST_PRESC;
         cur.pop    <= 1'b0;
         cur.fwr    <= 1'b0;
         cur.fdata  <= 8'h00;
         cur.rdata  <= 32'h0000_0000;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   // outputs straight from flip-flops; osc_stopped is decoded from the state
   assign stack_pop        = cur.pop;
   assign file_wr_en       = cur.fwr;
   assign file_wdata       = cur.fdata;
   assign accumulator      = cur.acc;
   assign program_counter  = cur.pc;
   assign carry            = cur.carry;
   assign nibble_carry     = cur.nibble;
   assign zero             = cur.zero;
   assign timeout_flag_n   = cur.to_n;
   assign powerdown_flag_n = cur.pd_n;
   assign osc_stopped      = (cur.state == exec_pkg::ST_SLEEP);
   assign reg_rdata        = cur.rdata;

endmodule

// File: rtl/exec_pkg.sv
// constants, encodings and register map of the execution unit
// assumes one 40 MHz clock and a synchronous active-high reset
package exec_pkg;

   // data and address widths
   localparam int DATA_W = 8;
   localparam int PC_W   = 15;
   localparam int ADDR_W = 4;

   // clock rate, for reference by derived counts
   localparam int CLK_PERIOD_NS = 25;

   // cycles taken by each instruction class
   localparam int RET_CYCLES = 2;
   localparam int ONE_CYCLES = 1;

   // register byte offsets on the software port
   localparam logic [3:0] OFS_ACC   = 4'h0;
   localparam logic [3:0] OFS_FLAGS = 4'h4;
   localparam logic [3:0] OFS_PC    = 4'h8;
   localparam logic [3:0] OFS_WDOG  = 4'hc;

   // bit positions in the flags register
   localparam int FLAG_CARRY  = 0;
   localparam int FLAG_NIBBLE = 1;
   localparam int FLAG_ZERO   = 2;
   localparam int FLAG_TO_N   = 3;
   localparam int FLAG_PD_N   = 4;

   // values after reset
   localparam logic [7:0]  RST_ACC    = 8'h00;
   localparam logic [14:0] RST_PC     = 15'h0000;
   localparam logic [7:0]  RST_WDOG   = 8'h00;
   localparam logic [7:0]  RST_PRESC  = 8'h00;
   localparam logic        RST_TO_N   = 1'b1;
   localparam logic        RST_PD_N   = 1'b1;

   // watchdog cleared value
   localparam logic [7:0]  WDOG_CLEAR = 8'h00;

   // instruction selector, one-hot
   typedef enum logic [4:0] {
      OP_RET_LIT = 5'b0_0001,
      OP_ROT_L   = 5'b0_0010,
      OP_ROT_R   = 5'b0_0100,
      OP_SUB_LIT = 5'b0_1000,
      OP_SLEEP   = 5'b1_0000
   } op_t;

   // sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_FLUSH = 3'b010,
      ST_SLEEP = 3'b100
   } state_t;

endpackage

// File: rtl/alu_if.sv
// signals between the sequencer and its arithmetic unit
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface alu_if;
   exec_pkg::op_t    op;
   logic [7:0]       operand;
   logic [7:0]       file_data;
   logic [7:0]       acc;
   logic             carry_in;
   logic [7:0]       result;
   logic             carry_out;
   logic             nibble_out;
   logic             zero_out;

   modport alu
   (
      input  op,
      input  operand,
      input  file_data,
      input  acc,
      input  carry_in,
      output result,
      output carry_out,
      output nibble_out,
      output zero_out
   );

   modport user
   (
      output op,
      output operand,
      output file_data,
      output acc,
      output carry_in,
      input  result,
      input  carry_out,
      input  nibble_out,
      input  zero_out
   );
endinterface

// File: rtl/rot_sub_alu.sv
// combinational rotate and literal-subtract unit
// assumes the sequencer registers everything it takes from here
`timescale 1ns/1ps
module rot_sub_alu
(
   alu_if.alu port
);

   logic [8:0] full_diff;
   logic [4:0] low_diff;

   // borrow-free subtraction: literal plus inverted accumulator plus one
   always_comb
   begin
      full_diff = {1'b0, port.operand} + {1'b0, ~port.acc} + 9'h001;
      low_diff  = {1'b0, port.operand[3:0]} + {1'b0, ~port.acc[3:0]}
                  + 5'h01;
   end

   // result selection per operation
   always_comb
   begin
      port.result     = 8'h00;
      port.carry_out  = port.carry_in;
      port.nibble_out = 1'b0;
      port.zero_out   = 1'b0;
      unique case (port.op)
         exec_pkg::OP_ROT_L:
         begin
            port.result    = {port.file_data[6:0], port.carry_in};
            port.carry_out = port.file_data[7];
         end
         exec_pkg::OP_ROT_R:
         begin
            port.result    = {port.carry_in, port.file_data[7:1]};
            port.carry_out = port.file_data[0];
         end
         exec_pkg::OP_SUB_LIT:
         begin
            port.result     = full_diff[7:0];
            port.carry_out  = full_diff[8];
            port.nibble_out = low_diff[4];
            port.zero_out   = (full_diff[7:0] == 8'h00);
         end
         exec_pkg::OP_RET_LIT:
            port.result = port.operand;
         default:
            port.result = 8'h00;
      endcase
   end

endmodule

// File: test/exec_unit_chk.sv
// timing and value checks for the execution unit, bound to its top
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module exec_unit_chk
(
   input wire logic           clk,
   input wire logic           sys_rst,
   input wire logic           issue_valid,
   input wire exec_pkg::op_t  issue_op,
   input wire logic [7:0]     issue_operand,
   input wire logic           issue_dest,
   input wire logic [7:0]     file_rdata,
   input wire logic           issue_ready,
   input wire logic [14:0]    stack_top,
   input wire logic           stack_pop,
   input wire logic           file_wr_en,
   input wire logic [7:0]     file_wdata,
   input wire logic [7:0]     accumulator,
   input wire logic [14:0]    program_counter,
   input wire logic           carry,
   input wire logic           nibble_carry,
   input wire logic           zero,
   input wire logic           timeout_flag_n,
   input wire logic           powerdown_flag_n,
   input wire logic           osc_stopped,
   input wire logic           wake
);
   logic take;
   // an instruction is taken on an edge with valid and ready
   assign take = issue_valid && issue_ready;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_ret_loads: assert property (
      take && issue_op == exec_pkg::OP_RET_LIT
      |=> accumulator == $past(issue_operand)
      && program_counter == $past(stack_top)) else $error("return load");
   a_ret_pop_gap: assert property (
      take && issue_op == exec_pkg::OP_RET_LIT
      |=> stack_pop && !issue_ready ##1 !stack_pop && issue_ready)
      else $error("return timing");
   a_rotl_value: assert property (
      take && issue_op == exec_pkg::OP_ROT_L && !issue_dest
      |=> accumulator == {$past(file_rdata[6:0]), $past(carry)}
      && carry == $past(file_rdata[7]) && $stable(zero)
      && $stable(nibble_carry)) else $error("rotate left");
   a_rotr_file: assert property (
      take && issue_op == exec_pkg::OP_ROT_R && issue_dest
      |=> file_wr_en && carry == $past(file_rdata[0])
      && file_wdata == {$past(carry), $past(file_rdata[7:1])}
      && $stable(accumulator)) else $error("rotate right");
   a_rot_dest_acc: assert property (
      take && !issue_dest
      && (issue_op == exec_pkg::OP_ROT_L || issue_op == exec_pkg::OP_ROT_R)
      |=> !file_wr_en) else $error("rotate wrote file");
   a_sub_value: assert property (
      take && issue_op == exec_pkg::OP_SUB_LIT
      |=> accumulator == 8'($past(issue_operand) - $past(accumulator))
      && carry == ($past(accumulator) <= $past(issue_operand))
      && nibble_carry
         == ($past(accumulator[3:0]) <= $past(issue_operand[3:0]))
      && zero == (accumulator == 8'h00)) else $error("subtract");
   a_sleep_flags: assert property (
      take && issue_op == exec_pkg::OP_SLEEP
      |=> !powerdown_flag_n && timeout_flag_n && osc_stopped)
      else $error("sleep flags");
   a_sleep_halt: assert property (osc_stopped |-> !issue_ready)
      else $error("ready while asleep");
   a_one_cycle: assert property (
      take && (issue_op == exec_pkg::OP_ROT_L
      || issue_op == exec_pkg::OP_ROT_R || issue_op == exec_pkg::OP_SUB_LIT)
      |=> issue_ready && program_counter == 15'($past(program_counter) + 1))
      else $error("single cycle");
   c_ret: cover property (take && issue_op == exec_pkg::OP_RET_LIT);
   c_wake: cover property (osc_stopped && wake ##1 !osc_stopped);
   c_file_wr: cover property (file_wr_en);
endmodule
bind exec_unit exec_unit_chk u_exec_unit_chk (.clk, .sys_rst, .issue_valid,
   .issue_op, .issue_operand, .issue_dest, .file_rdata, .issue_ready,
   .stack_top, .stack_pop, .file_wr_en, .file_wdata, .accumulator,
   .program_counter, .carry, .nibble_carry, .zero, .timeout_flag_n,
   .powerdown_flag_n, .osc_stopped, .wake);

// File: test/test_exec_unit.sv
// self-checking bench for the execution unit against an integer model
// assumes the design package is compiled first
`timescale 1ns/1ps
module test_exec_unit;
   logic clk, sys_rst, issue_valid, issue_dest, wake, reg_wr, reg_rd;
   logic issue_ready, stack_pop, file_wr_en, carry, nibble_carry, zero;
   logic timeout_flag_n, powerdown_flag_n, osc_stopped;
   exec_pkg::op_t issue_op;
   logic [7:0]    issue_operand, file_rdata, file_wdata, accumulator;
   logic [14:0]   stack_top, program_counter;
   logic [3:0]    reg_addr;
   logic [31:0]   reg_wdata, reg_rdata;
   int            m_acc, m_c, m_nc, m_z, m_pc, m_to, m_pd;
   int            err_total, tests_run, cycles, n;
   exec_unit u_exec_unit (.clk, .sys_rst, .issue_valid, .issue_op,
      .issue_operand, .issue_dest, .file_rdata, .issue_ready, .stack_top,
      .stack_pop, .file_wr_en, .file_wdata, .accumulator, .program_counter,
      .carry, .nibble_carry, .zero, .timeout_flag_n, .powerdown_flag_n,
      .osc_stopped, .wake, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata);
   // free-running 25 ns clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] got, input int exp);
      tests_run++;
      if (got !== 32'(exp))
      begin
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask
   function automatic int flags();
      return m_c | m_nc << 1 | m_z << 2 | m_to << 3 | m_pd << 4;
   endfunction
   // one-cycle strobed register access, read data checked next cycle
   task automatic reg_acc(input logic [3:0] a, input int v, input bit rd);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= 32'(v);
      if (rd) reg_rd <= 1'b1;
      else reg_wr <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      #1;
      if (rd) chk(reg_rdata, v);
   endtask
   // offer one instruction, then compare the model after it is taken
   task automatic issue(input exec_pkg::op_t op, input int k, d, f);
      int r;
      // the pins carry only eight bits of literal and file value
      f = f & 255;
      k = k & 255;
      @(posedge clk);
      issue_valid <= 1'b1;
      issue_op <= op;
      issue_operand <= 8'(k);
      issue_dest <= d[0];
      file_rdata <= 8'(f);
      @(posedge clk);
      issue_valid <= 1'b0;
      #1;
      r = m_acc;
      case (op)
         exec_pkg::OP_ROT_L: r = ((f << 1) & 255) | m_c;
         exec_pkg::OP_ROT_R: r = (f >> 1) | (m_c << 7);
         exec_pkg::OP_SUB_LIT:
         begin
            r = (k - m_acc) & 255;
            m_c = int'(m_acc <= k);
            m_nc = int'((m_acc & 15) <= (k & 15));
            m_z = int'(r == 0);
         end
         exec_pkg::OP_RET_LIT: r = k;
         default: m_pd = 0;
      endcase
      if (op == exec_pkg::OP_ROT_L) m_c = (f >> 7) & 1;
      if (op == exec_pkg::OP_ROT_R) m_c = f & 1;
      n = int'(op == exec_pkg::OP_ROT_L || op == exec_pkg::OP_ROT_R) & d;
      chk(file_wr_en, n);
      if (n == 1) chk(file_wdata, r);
      else m_acc = r;
      m_pc = (op == exec_pkg::OP_RET_LIT) ? stack_top : (m_pc + 1) & 32767;
      chk(accumulator, m_acc);
      chk({carry, nibble_carry, zero}, m_c << 2 | m_nc << 1 | m_z);
      chk({powerdown_flag_n, timeout_flag_n, zero, nibble_carry, carry},
          flags());
      chk(program_counter, m_pc);
      chk(stack_pop, op == exec_pkg::OP_RET_LIT);
      chk(issue_ready, op != exec_pkg::OP_RET_LIT
          && op != exec_pkg::OP_SLEEP);
   endtask
   initial
   begin
      {issue_valid, issue_dest, wake, reg_wr, reg_rd} = 5'h0;
      {issue_operand, file_rdata, reg_addr, reg_wdata} = 52'h0;
      issue_op = exec_pkg::OP_ROT_L;
      stack_top = 15'h0000;
      {m_acc, m_c, m_nc, m_z, m_pc, err_total, tests_run, cycles} = 0;
      m_to = 1;
      m_pd = 1;
      sys_rst = 1'b1;
      n = $urandom(94);
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      reg_acc(exec_pkg::OFS_FLAGS, flags(), 1);
      reg_acc(exec_pkg::OFS_PC, 'h1234, 0);
      reg_acc(4'h2, 'h55, 0);
      reg_acc(exec_pkg::OFS_PC, 0, 1);
      m_acc = 'h10;
      reg_acc(exec_pkg::OFS_ACC, m_acc, 0);
      issue(exec_pkg::OP_SUB_LIT, 'h0f, 0, 0);
      issue(exec_pkg::OP_SUB_LIT, 'hff, 0, 0);
      // random rotates and subtracts, one idle cycle apart
      repeat (80)
      begin
         n = $urandom % 3;
         issue(n == 0 ? exec_pkg::OP_ROT_L : n == 1 ? exec_pkg::OP_ROT_R
            : exec_pkg::OP_SUB_LIT, $urandom, $urandom, $urandom);
      end
      repeat (3)
      begin
         @(posedge clk);
         stack_top <= 15'($urandom);
         issue(exec_pkg::OP_RET_LIT, $urandom, 0, 0);
         issue(exec_pkg::OP_ROT_R, 0, 1, $urandom);
      end
      repeat (300) @(posedge clk);
      issue(exec_pkg::OP_SLEEP, 0, 0, 0);
      chk(osc_stopped, 1);
      reg_acc(exec_pkg::OFS_WDOG, 0, 1);
      reg_acc(exec_pkg::OFS_FLAGS, flags(), 1);
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      #1;
      chk(osc_stopped, 0);
      issue(exec_pkg::OP_ROT_L, 0, 0, $urandom);
      wrap_up();
   end
endmodule
